/* rtl/dcfbh_pkg.sv */
// constants and types for the dual-processor flush bus handoff sequencer
// assumes a single synchronous clock domain shared by both processors
package dcfbh_pkg;
    typedef enum logic [2:0] {
        DCFBH_IDLE      = 3'b000,
        DCFBH_TO_SEC    = 3'b001,
        DCFBH_SEC_FLUSH = 3'b011,
        DCFBH_TO_PRI    = 3'b010,
        DCFBH_PRI_FLUSH = 3'b110,
        DCFBH_ACK       = 3'b111
    } dcfbh_state_t;
    localparam logic       DCFBH_OWNER_PRI = 1'b0;
    localparam logic       DCFBH_OWNER_SEC = 1'b1;
    localparam logic [1:0] DCFBH_RATIO_W   = 2'd3;
    localparam logic [2:0] DCFBH_RATIO_2_7 = 3'h3;
endpackage

/* rtl/dcfbh_seq.sv */
// flush sequencer and bus owner arbiter for two processors on one bus
// assumes flush engines report completion with one-cycle done pulses
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - flush request in dual processor mode first hands bus to secondary
// - secondary owning bus flushes its cache
// - secondary done returns bus to primary
// - secondary waits silent until primary finishes
// - primary flushes then drives flush acknowledge
// - acknowledge releases secondary, normal operation resumes
// - secondary bus requests blocked before acknowledge
module dcfbh_seq
    import dcfbh_pkg::*;
(
    input  wire logic       sys_clk_in,
    input  wire logic       nrst_in,
    input  wire logic       dual_processor_mode_in,
    input  wire logic [2:0] bus_ratio_in,
    input  wire logic       flush_req_in,
    input  wire logic       pri_bus_req_in,
    input  wire logic       sec_bus_req_in,
    input  wire logic       sec_flush_done_in,
    input  wire logic       pri_flush_done_in,
    output logic            bus_owner_out,
    output logic            pri_grant_out,
    output logic            sec_grant_out,
    output logic            sec_flush_start_out,
    output logic            pri_flush_start_out,
    output logic            flush_ack_cycle_out,
    output logic            sec_waiting_out,
    output logic            flush_busy_out,
    output logic            ratio_2_7_out
);
    dcfbh_state_t state;
    dcfbh_state_t next_state;
    logic         owner;
    logic         next_owner;
    logic         sec_start;
    logic         next_sec_start;
    logic         pri_start;
    logic         next_pri_start;
    logic         ack;
    logic         next_ack;

    always_comb begin
        next_state     = state;
        next_owner     = owner;
        next_sec_start = 1'b0;
        next_pri_start = 1'b0;
        next_ack       = 1'b0;
        case (state)
            DCFBH_IDLE: begin
                if (flush_req_in && dual_processor_mode_in) begin
                    next_owner = DCFBH_OWNER_SEC;
                    next_state = DCFBH_TO_SEC;
                end else if (owner == DCFBH_OWNER_PRI && !pri_bus_req_in && sec_bus_req_in) begin
                    next_owner = DCFBH_OWNER_SEC;
                end else if (owner == DCFBH_OWNER_SEC && !sec_bus_req_in && pri_bus_req_in) begin
                    next_owner = DCFBH_OWNER_PRI;
                end
            end
            DCFBH_TO_SEC: begin
                next_sec_start = 1'b1;
                next_state     = DCFBH_SEC_FLUSH;
            end
            DCFBH_SEC_FLUSH: begin
                if (sec_flush_done_in) begin
                    next_owner = DCFBH_OWNER_PRI;
                    next_state = DCFBH_TO_PRI;
                end
            end
            DCFBH_TO_PRI: begin
                next_pri_start = 1'b1;
                next_state     = DCFBH_PRI_FLUSH;
            end
            DCFBH_PRI_FLUSH: begin
                if (pri_flush_done_in) begin
                    next_ack   = 1'b1;
                    next_state = DCFBH_ACK;
                end
            end
            DCFBH_ACK: begin
                next_owner = DCFBH_OWNER_PRI;
                next_state = DCFBH_IDLE;
            end
            default: begin
                next_owner = DCFBH_OWNER_PRI;
                next_state = DCFBH_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state     <= DCFBH_IDLE;
            owner     <= DCFBH_OWNER_PRI;
            sec_start <= 1'b0;
            pri_start <= 1'b0;
            ack       <= 1'b0;
        end else begin
            state     <= next_state;
            owner     <= next_owner;
            sec_start <= next_sec_start;
            pri_start <= next_pri_start;
            ack       <= next_ack;
        end
    end

    // secondary held off in every phase after it gives the bus back, any ratio
    assign sec_waiting_out     = (state == DCFBH_TO_PRI) || (state == DCFBH_PRI_FLUSH)
                                 || (state == DCFBH_ACK);
    assign bus_owner_out       = owner;
    assign pri_grant_out       = (owner == DCFBH_OWNER_PRI);
    assign sec_grant_out       = (owner == DCFBH_OWNER_SEC) && !sec_waiting_out;
    assign sec_flush_start_out = sec_start;
    assign pri_flush_start_out = pri_start;
    assign flush_ack_cycle_out = ack;
    assign flush_busy_out      = (state != DCFBH_IDLE);
    assign ratio_2_7_out       = (bus_ratio_in == DCFBH_RATIO_2_7);
endmodule
`default_nettype wire

/* test/dcfbh_checker.sv */
// port assertions for the flush handoff sequencer, bound onto dcfbh_seq
`timescale 1ns/1ps
`default_nettype none
module dcfbh_checker (
    input wire logic sys_clk_in, nrst_in, flush_req_in, dual_processor_mode_in, sec_flush_done_in,
    input wire logic pri_flush_done_in, bus_owner_out, sec_grant_out, sec_flush_start_out,
    input wire logic pri_flush_start_out, flush_ack_cycle_out, sec_waiting_out, flush_busy_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!nrst_in);
    sequence s_to_sec; bus_owner_out ##1 sec_flush_start_out; endsequence
    sequence s_to_pri; !bus_owner_out && sec_waiting_out ##1 pri_flush_start_out; endsequence
    a_take_flush: assert property (!flush_busy_out && flush_req_in && dual_processor_mode_in
        |=> s_to_sec) else $error("no handoff");
    a_sec_owns: assert property (sec_flush_start_out |-> bus_owner_out) else $error("s");
    a_give_back: assert property (flush_busy_out && bus_owner_out && sec_flush_done_in
        |=> s_to_pri) else $error("no return");
    a_wait_quiet: assert property (sec_waiting_out |-> !sec_grant_out) else $error("w");
    a_ack_cause: assert property (flush_ack_cycle_out |-> $past(pri_flush_done_in)) else $error("a");
    a_ack_after: assert property (sec_waiting_out && pri_flush_done_in |=> flush_ack_cycle_out)
        else $error("no ack");
    a_idle_again: assert property (flush_ack_cycle_out |=> !flush_busy_out && !sec_waiting_out
        && !bus_owner_out) else $error("no resume");
    a_mode_off: assert property (!flush_busy_out && !dual_processor_mode_in |=> !flush_busy_out)
        else $error("taken");
endmodule
bind dcfbh_seq dcfbh_checker u_chk (.*);
`default_nettype wire

/* test/dcfbh_peer.sv */
// far-side flush engines: each start is answered by a done pulse after peer_delay cycles
`timescale 1ns/1ps
`default_nettype none
module dcfbh_peer (
    input  wire logic       sys_clk_in, nrst_in, sec_flush_start_out, pri_flush_start_out,
    input  wire logic [3:0] peer_delay,
    output logic            sec_flush_done_in, pri_flush_done_in
);
    logic [3:0] sc, pc;
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) {sc, pc} <= 8'h00;
        else {sc, pc} <= {sec_flush_start_out ? peer_delay : sc - {3'h0, sc != 4'h0},
                          pri_flush_start_out ? peer_delay : pc - {3'h0, pc != 4'h0}};
    end
    assign sec_flush_done_in = sc == 4'h1;
    assign pri_flush_done_in = pc == 4'h1;
endmodule
`default_nettype wire

/* test/tb_top.sv */
// self-checking bench for the flush handoff sequencer with the peer engines
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import dcfbh_pkg::*;
    logic sys_clk_in = 0, nrst_in = 0, dual_processor_mode_in = 0, flush_req_in = 0;
    logic pri_bus_req_in = 0, sec_bus_req_in = 1, sec_flush_done_in, pri_flush_done_in;
    logic bus_owner_out, pri_grant_out, sec_grant_out, sec_flush_start_out, pri_flush_start_out;
    logic flush_ack_cycle_out, sec_waiting_out, flush_busy_out, ratio_2_7_out;
    logic [2:0] bus_ratio_in = 3'h0;
    logic [3:0] peer_delay = 4'h1;
    int fail_count = 0, check_count = 0;
    initial forever #20 sys_clk_in = ~sys_clk_in;
    dcfbh_seq u_dut (.*);
    dcfbh_peer u_peer (.*);
    task automatic chk(input logic ok, input string m);
        check_count++;
        if (ok !== 1'b1) begin
            fail_count++;
            $display("mismatch %0t %s", $time, m);
        end
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic flush_run(input logic [2:0] r, input logic [3:0] d);
        int n;
        bus_ratio_in = r;
        peer_delay = d;
        flush_req_in = 1;
        @(negedge sys_clk_in) flush_req_in = 0;
        chk(bus_owner_out === 1'b1 && flush_busy_out === 1'b1, "owner");
        for (n = 0; n < 60 && flush_ack_cycle_out !== 1'b1; n++) @(negedge sys_clk_in);
        chk(n < 60 && sec_waiting_out === 1'b1, "ack");
        if (n >= 60) close_out();
        chk(ratio_2_7_out === (r == DCFBH_RATIO_2_7) && sec_grant_out === 1'b0, "ratio");
        @(negedge sys_clk_in);
        chk({flush_busy_out, sec_waiting_out, bus_owner_out, pri_grant_out} === 4'h1, "resume");
        @(negedge sys_clk_in);
        chk(bus_owner_out === 1'b1 && sec_grant_out === 1'b1, "arbitration");
        $display("flush test done");
    endtask
    initial begin
        repeat (16) @(negedge sys_clk_in);
        nrst_in = 1;
        flush_req_in = 1;
        repeat (2) @(negedge sys_clk_in);
        chk(flush_busy_out === 1'b0, "refuse");
        dual_processor_mode_in = 1;
        flush_run(3'h0, 4'h1);
        flush_run(DCFBH_RATIO_2_7, 4'h9);
        close_out();
    end
endmodule
`default_nettype wire
